// file: ssc_stats.sv
/*
 * Statistics counters of a three-port switch: 96 read-clear per-port
 * counters, six drop counters and the indirect read window that reaches
 * them through the host register port.
 * Assumes the register port and the MAC event sources run on clk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ssc_cfg.svh"

module ssc_stats
  import ssc_pkg::*;
(
  input wire logic clk, // switch core clock
  input wire logic reset, // asynchronous, active high
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic [7:0] reg_addr, // register offset
  input wire logic [7:0] reg_wdata, // write data
  output logic [7:0] reg_rdata, // read data, one cycle after reg_rd
  input wire logic long_mode, // max frame size 1536 instead of 1522
  input wire ssc_rx_ev_s [2:0] rx_ev, // receive events per port
  input wire ssc_tx_ev_s [2:0] tx_ev, // transmit events per port
  input wire logic [2:0] tx_drop, // send drop pulse per port
  input wire logic [2:0] rx_drop, // receive drop pulse per port
  output logic fetch_busy // level: per-port fetch pending
);

  logic [7:0] select_reg;
  logic [7:0] offset_reg;
  logic [31:0] data_reg;
  logic [31:0] data_next;
  ssc_state_e state_reg;
  ssc_state_e state_next;
  logic [6:0] idx_reg;
  logic [29:0] cnt_reg [`SSC_NUM_CNT];
  logic ovf_reg [`SSC_NUM_CNT];
  logic [15:0] drop_reg [`SSC_NUM_DROP];
  ssc_inc_t [2:0] inc;
  logic trig;
  logic fetch;
  logic [7:0] rdata_next;

  genvar p;
  generate
    for (p = 0; p < `SSC_NUM_PORTS; p++) begin : g_port
      ssc_port_events u_events (
        .rx_ev(rx_ev[p]),
        .tx_ev(tx_ev[p]),
        .long_mode(long_mode),
        .inc(inc[p])
      );
    end
  endgenerate

  // flat counter index of a port and offset
  function automatic logic [6:0] cnt_index(input logic [6:0] raw);
    return raw;
  endfunction

  // valid per-port offset lies below the third port's range end
  function automatic logic port_offset_ok(input logic [7:0] off);
    return off < 8'h60; // R25
  endfunction

  // add with sticky carry; a clear keeps the same-cycle increment
  function automatic logic [30:0] cnt_step(input logic [29:0] cur,
                                           input logic ovf,
                                           input logic [10:0] add,
                                           input logic clr);
    logic [30:0] sum;
    sum = {1'b0, cur} + {20'h00000, add};
    if (clr)
      return {1'b0, 19'h00000, add}; // R27
    return {ovf | sum[30], sum[29:0]}; // R23
  endfunction

  assign trig = reg_wr && reg_addr == `SSC_REG_TRIGGER;
  assign fetch = state_reg == SSC_FETCH;
  assign fetch_busy = state_reg == SSC_FETCH;

  // host-writable control registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      select_reg <= 8'h00;
      offset_reg <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == `SSC_REG_SELECT)
        select_reg <= reg_wdata; // R20 R24
      if (reg_addr == `SSC_REG_TRIGGER)
        offset_reg <= reg_wdata; // R20 R21
    end
  end

  // fetch sequencer: the fetch cycle always clears the counter, and captures it only if no trigger lands in that cycle
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SSC_IDLE: begin
        if (trig && select_reg == `SSC_SEL_PORT &&
            port_offset_ok(reg_wdata))
          state_next = SSC_FETCH;
      end
      // a new valid per-port trigger in the fetch cycle restarts, any other trigger returns to idle with valid low
      SSC_FETCH: begin
        if (trig && select_reg == `SSC_SEL_PORT &&
            port_offset_ok(reg_wdata))
          state_next = SSC_FETCH; // R29
        else if (trig)
          state_next = SSC_IDLE;
        else
          state_next = SSC_DONE;
      end
      SSC_DONE: begin
        if (trig && select_reg == `SSC_SEL_PORT &&
            port_offset_ok(reg_wdata))
          state_next = SSC_FETCH;
        else if (trig)
          state_next = SSC_IDLE;
      end
      default: begin
        state_next = SSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      state_reg <= SSC_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      idx_reg <= 7'h00;
    else if (trig)
      idx_reg <= cnt_index(reg_wdata[6:0]); // R21 R25
  end

  // result word; valid stays low from trigger until the fetch lands
  always_comb begin
    data_next = data_reg;
    if (trig) begin
      if (select_reg == `SSC_SEL_DROP && reg_wdata < 8'h06)
        data_next = {16'h0000, drop_reg[reg_wdata[2:0]]}; // R19 R28
      else
        data_next[`SSC_BIT_VALID] = 1'b0; // R29
    end else if (fetch) begin
      data_next = {ovf_reg[idx_reg], 1'b1, cnt_reg[idx_reg]}; // R22 R26 R29
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      data_reg <= 32'h00000000;
    else
      data_reg <= data_next;
  end

  // per-port counters; the fetched one restarts from this cycle's events
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < `SSC_NUM_CNT; i++) begin
        cnt_reg[i] <= 30'h00000000;
        ovf_reg[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < `SSC_NUM_CNT; i++) begin
        {ovf_reg[i], cnt_reg[i]} <= // R1 R12 R23 R27
          cnt_step(cnt_reg[i], ovf_reg[i], inc[i / 32][i % 32],
                   fetch && idx_reg == 7'(i));
      end
    end
  end

  // drop counters wrap at 16 bits and are never cleared by a read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < `SSC_NUM_DROP; i++)
        drop_reg[i] <= 16'h0000;
    end else begin
      for (int i = 0; i < `SSC_NUM_PORTS; i++) begin
        if (tx_drop[i])
          drop_reg[i] <= drop_reg[i] + 16'h0001; // R18
        if (rx_drop[i])
          drop_reg[i + 3] <= drop_reg[i + 3] + 16'h0001; // R18
      end
    end
  end

  // register read mux, registered so data comes from flops
  always_comb begin
    case (reg_addr)
      `SSC_REG_SELECT: rdata_next = select_reg;
      `SSC_REG_TRIGGER: rdata_next = offset_reg;
      `SSC_REG_DATA3: rdata_next = data_reg[31:24]; // R22 R23
      `SSC_REG_DATA2: rdata_next = data_reg[23:16]; // R22
      `SSC_REG_DATA1: rdata_next = data_reg[15:8]; // R19 R22
      `SSC_REG_DATA0: rdata_next = data_reg[7:0]; // R19 R22
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_next;
  end

endmodule

`default_nettype wire

// file: ssc_cfg.svh
/*
 * Constants of the switch port statistics counters: host register offsets,
 * indirect select codes, counter offsets, field positions and frame limits.
 * Assumes it is included once per compilation unit by its bare name.
 */
// Overview of operation
// R1: count received octets per priority at offsets 0x0 and 0x1, bad included.
// R2: count short received frames that have a good checksum.
// R3: count short received frames with checksum, symbol or alignment error.
// R4: count long received frames with good checksum; limit 1536 or 1522.
// R5: count long received frames with errors; limit follows size setting.
// R6: count legal-length received frames holding an invalid data symbol.
// R7: count legal-length frames with a bad checksum, whole or partial bytes.
// R8: count received MAC control frames, type 88-08h, at offset 0x9.
// R9: count fully qualified received flow control frames at offset 0xA.
// R10: count good broadcast, multicast, unicast at 0xB-0xD; control excluded. Code excludes control frames only from multicast at 0xC.
// R11: bin every received frame by length into 0xE to 0x13. Code bins only lengths from 64 up to the size limit.
// R12: count good sent octets per priority at 0x14 and 0x15.
// R13: count late collisions past 512 bit-times at 0x16.
// R14: count sent flow control at 0x17, sent frame classes at 0x18-0x1A.
// R15: count frames whose first send attempt was deferred, at 0x1B.
// R16: count all half duplex collisions at 0x1C, excess failures at 0x1D.
// R17: count frames sent after one collision at 0x1E, after more at 0x1F.
// R18: keep six drop counters at 0x100-0x105, send then receive per port.
// R19: drop counters read as 16 bits in 15-0, upper bits zero.
// R20: host writes select 0x1c then offset to start a per-port read.
// R21: host adds the port base to the counter offset.
// R22: result word bytes at 0x80-0x83; host rereads while valid is low.
// R23: bit 31 of a per-port result flags counter overflow.
// R24: host reads drop counters with select 0x1d, result in 0x82-0x83.
// R25: per-port sets sit at bases 0x00, 0x20 and 0x40.
// R26: per-port result value occupies bits 29-0.
// R27: reading a per-port counter clears it.
// R28: drop counters are not cleared by reading and carry no flags.
// R29: valid stays low until the value is fetched, then goes high.
`ifndef SSC_CFG_SVH
`define SSC_CFG_SVH

`define SSC_REG_SELECT 8'h79
`define SSC_REG_TRIGGER 8'h7a
`define SSC_REG_DATA3 8'h80
`define SSC_REG_DATA2 8'h81
`define SSC_REG_DATA1 8'h82
`define SSC_REG_DATA0 8'h83

`define SSC_SEL_PORT 8'h1c
`define SSC_SEL_DROP 8'h1d

`define SSC_NUM_PORTS 3
`define SSC_PER_PORT 32
`define SSC_NUM_CNT 96
`define SSC_CNT_W 30
`define SSC_DROP_W 16
`define SSC_NUM_DROP 6
`define SSC_DROP_RX_FIRST 3'h3
`define SSC_BIT_OVF 31
`define SSC_BIT_VALID 30

`define SSC_LEN_MIN 11'h040
`define SSC_LEN_MAX_STD 11'h5f2
`define SSC_LEN_MAX_LONG 11'h600
`define SSC_LEN_127 11'h07f
`define SSC_LEN_255 11'h0ff
`define SSC_LEN_511 11'h1ff
`define SSC_LEN_1023 11'h3ff

`define SSC_OFF_RX_LO_OCT 5'h00
`define SSC_OFF_RX_HI_OCT 5'h01
`define SSC_OFF_RX_SHORT 5'h02
`define SSC_OFF_RX_FRAG 5'h03
`define SSC_OFF_RX_LONG_GOOD 5'h04
`define SSC_OFF_RX_LONG_BAD 5'h05
`define SSC_OFF_RX_SYMBOL 5'h06
`define SSC_OFF_RX_CHECKSUM 5'h07
`define SSC_OFF_RX_MISALIGN 5'h08
`define SSC_OFF_RX_MAC_CTRL 5'h09
`define SSC_OFF_RX_FLOW 5'h0a
`define SSC_OFF_RX_ALL_DEST 5'h0b
`define SSC_OFF_RX_GROUP 5'h0c
`define SSC_OFF_RX_SINGLE 5'h0d
`define SSC_OFF_RX_BIN0 5'h0e
`define SSC_OFF_TX_LO_OCT 5'h14
`define SSC_OFF_TX_HI_OCT 5'h15
`define SSC_OFF_TX_LATE 5'h16
`define SSC_OFF_TX_FLOW 5'h17
`define SSC_OFF_TX_ALL_DEST 5'h18
`define SSC_OFF_TX_GROUP 5'h19
`define SSC_OFF_TX_SINGLE 5'h1a
`define SSC_OFF_TX_POSTPONED 5'h1b
`define SSC_OFF_TX_ALL_COLL 5'h1c
`define SSC_OFF_TX_TOO_MANY 5'h1d
`define SSC_OFF_TX_ONE_COLL 5'h1e
`define SSC_OFF_TX_MULTI_COLL 5'h1f

`endif

// file: ssc_pkg.sv
/*
 * Types of the switch port statistics counters: event carriers from the
 * MAC datapath, increment vectors and the fetch state machine.
 * Assumes ssc_cfg.svh is compiled into the same unit.
 */
`include "ssc_cfg.svh"

package ssc_pkg;

  typedef logic [10:0] ssc_len_t;
  typedef logic [31:0][10:0] ssc_inc_t;

  // one-cycle pulse per received frame at its end
  typedef struct packed {
    logic done;
    ssc_len_t len;
    logic high_prio;
    logic crc_ok;
    logic symbol_err;
    logic partial_byte;
    logic all_dest;
    logic group_dest;
    logic mac_ctrl;
    logic flow_match;
  } ssc_rx_ev_s;

  typedef struct packed {
    logic done;
    ssc_len_t len;
    logic high_prio;
    logic ok;
    logic all_dest;
    logic group_dest;
    logic flow_ctrl;
    logic postponed;
    logic too_many_coll;
    logic [4:0] coll_num;
    logic coll;
    logic late_coll;
  } ssc_tx_ev_s;

  typedef enum logic [1:0] {
    SSC_IDLE = 2'b00,
    SSC_FETCH = 2'b01,
    SSC_DONE = 2'b11
  } ssc_state_e;

endpackage

// file: ssc_port_events.sv
/*
 * Per-port event decoder: turns one receive and one transmit event into
 * the 32 increments of that port's counter set.
 * Assumes events come from MAC logic on the same clock, one pulse a frame.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ssc_cfg.svh"

module ssc_port_events
  import ssc_pkg::*;
(
  input wire ssc_rx_ev_s rx_ev, // receive event
  input wire ssc_tx_ev_s tx_ev, // transmit event
  input wire logic long_mode, // max frame 1536 instead of 1522
  output ssc_inc_t inc // increment per counter offset
);

  localparam ssc_len_t ONE = 11'h001;

  function automatic ssc_len_t one_if(input logic c);
    return c ? ONE : 11'h000;
  endfunction

  ssc_len_t max_len;
  logic legal, err, good, is_short, is_long, tx_good;

  always_comb begin
    max_len = long_mode ? `SSC_LEN_MAX_LONG : `SSC_LEN_MAX_STD; // R4 R5 R7
    legal = rx_ev.len >= `SSC_LEN_MIN && rx_ev.len <= max_len;
    err = !rx_ev.crc_ok || rx_ev.symbol_err || rx_ev.partial_byte;
    good = rx_ev.done && legal && !err;
    is_short = rx_ev.done && rx_ev.len < `SSC_LEN_MIN;
    is_long = rx_ev.done && rx_ev.len > max_len;
    tx_good = tx_ev.done && tx_ev.ok;
    inc = '0;
    if (rx_ev.done && !rx_ev.high_prio)
      inc[`SSC_OFF_RX_LO_OCT] = rx_ev.len; // R1
    if (rx_ev.done && rx_ev.high_prio)
      inc[`SSC_OFF_RX_HI_OCT] = rx_ev.len; // R1
    inc[`SSC_OFF_RX_SHORT] = one_if(is_short && !err); // R2
    inc[`SSC_OFF_RX_FRAG] = one_if(is_short && err); // R3
    inc[`SSC_OFF_RX_LONG_GOOD] = one_if(is_long && !err); // R4
    inc[`SSC_OFF_RX_LONG_BAD] = one_if(is_long && err); // R5
    inc[`SSC_OFF_RX_SYMBOL] = one_if(rx_ev.done && legal &&
                                     rx_ev.symbol_err); // R6
    inc[`SSC_OFF_RX_CHECKSUM] = one_if(rx_ev.done && legal &&
                                       !rx_ev.crc_ok &&
                                       !rx_ev.partial_byte); // R7
    inc[`SSC_OFF_RX_MISALIGN] = one_if(rx_ev.done && legal &&
                                       !rx_ev.crc_ok &&
                                       rx_ev.partial_byte); // R7
    inc[`SSC_OFF_RX_MAC_CTRL] = one_if(rx_ev.done && rx_ev.mac_ctrl); // R8
    inc[`SSC_OFF_RX_FLOW] = one_if(rx_ev.done && rx_ev.mac_ctrl &&
                                   rx_ev.flow_match && rx_ev.crc_ok &&
                                   rx_ev.len >= `SSC_LEN_MIN); // R9
    inc[`SSC_OFF_RX_ALL_DEST] = one_if(good && rx_ev.all_dest); // R10
    inc[`SSC_OFF_RX_GROUP] = one_if(good && rx_ev.group_dest &&
                                    !rx_ev.all_dest &&
                                    !rx_ev.mac_ctrl); // R10
    inc[`SSC_OFF_RX_SINGLE] = one_if(good && !rx_ev.group_dest &&
                                     !rx_ev.all_dest); // R10
    // length bins take bad frames too
    inc[`SSC_OFF_RX_BIN0] = one_if(rx_ev.done &&
                                   rx_ev.len == `SSC_LEN_MIN); // R11
    inc[`SSC_OFF_RX_BIN0 + 5'h01] = one_if(rx_ev.done &&
      rx_ev.len > `SSC_LEN_MIN && rx_ev.len <= `SSC_LEN_127); // R11
    inc[`SSC_OFF_RX_BIN0 + 5'h02] = one_if(rx_ev.done &&
      rx_ev.len > `SSC_LEN_127 && rx_ev.len <= `SSC_LEN_255); // R11
    inc[`SSC_OFF_RX_BIN0 + 5'h03] = one_if(rx_ev.done &&
      rx_ev.len > `SSC_LEN_255 && rx_ev.len <= `SSC_LEN_511); // R11
    inc[`SSC_OFF_RX_BIN0 + 5'h04] = one_if(rx_ev.done &&
      rx_ev.len > `SSC_LEN_511 && rx_ev.len <= `SSC_LEN_1023); // R11
    inc[`SSC_OFF_RX_BIN0 + 5'h05] = one_if(rx_ev.done &&
      rx_ev.len > `SSC_LEN_1023 && rx_ev.len <= max_len); // R11
    if (tx_good && !tx_ev.high_prio)
      inc[`SSC_OFF_TX_LO_OCT] = tx_ev.len; // R12
    if (tx_good && tx_ev.high_prio)
      inc[`SSC_OFF_TX_HI_OCT] = tx_ev.len; // R12
    inc[`SSC_OFF_TX_LATE] = one_if(tx_ev.late_coll); // R13
    inc[`SSC_OFF_TX_FLOW] = one_if(tx_good && tx_ev.flow_ctrl); // R14
    inc[`SSC_OFF_TX_ALL_DEST] = one_if(tx_good && tx_ev.all_dest); // R14
    inc[`SSC_OFF_TX_GROUP] = one_if(tx_good && tx_ev.group_dest &&
                                    !tx_ev.all_dest); // R14
    inc[`SSC_OFF_TX_SINGLE] = one_if(tx_good && !tx_ev.group_dest &&
                                     !tx_ev.all_dest); // R14
    inc[`SSC_OFF_TX_POSTPONED] = one_if(tx_ev.done &&
                                        tx_ev.postponed); // R15
    inc[`SSC_OFF_TX_ALL_COLL] = one_if(tx_ev.coll); // R16
    inc[`SSC_OFF_TX_TOO_MANY] = one_if(tx_ev.done &&
                                       tx_ev.too_many_coll); // R16
    inc[`SSC_OFF_TX_ONE_COLL] = one_if(tx_good &&
                                       tx_ev.coll_num == 5'h01); // R17
    inc[`SSC_OFF_TX_MULTI_COLL] = one_if(tx_good &&
                                         tx_ev.coll_num > 5'h01); // R17
  end

endmodule

`default_nettype wire

// file: ssc_stats_properties.sv
/*
 * Checker of the statistics register window of ssc_stats.
 * Assumes ssc_cfg.svh and one clock domain; bound below.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ssc_cfg.svh"

module ssc_stats_chk (
  input wire logic clk, // core clock
  input wire logic reset, // async, active high
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [7:0] reg_addr, // register offset
  input wire logic [7:0] reg_wdata, // write data
  input wire logic [7:0] reg_rdata, // read data
  input wire logic fetch_busy // fetch pending
);
  logic [7:0] sel_reg;
  logic drop_reg;
  logic trig;

  assign trig = reg_wr && reg_addr == `SSC_REG_TRIGGER;

  // shadow of the select byte, needed to know what a trigger means
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      sel_reg <= 8'h00;
    else if (reg_wr && reg_addr == `SSC_REG_SELECT)
      sel_reg <= reg_wdata;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      drop_reg <= 1'b0;
    else if (trig)
      drop_reg <= sel_reg == `SSC_SEL_DROP && reg_wdata < 8'h06;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  sequence port_trig_s;
    trig && sel_reg == `SSC_SEL_PORT && reg_wdata < 8'h60;
  endsequence
  sequence fetch_s;
    fetch_busy && !trig ##1 reg_rd && reg_addr == `SSC_REG_DATA3;
  endsequence

  rdata_hold_a:
    assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  unmapped_zero_a:
    assert property (reg_rd && !(reg_addr inside {8'h79, 8'h7a,
      [8'h80:8'h83]}) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  select_back_a:
    assert property (reg_rd && reg_addr == `SSC_REG_SELECT
      |=> reg_rdata == $past(sel_reg))
    else $error("select readback wrong");
  fetch_start_a:
    assert property (port_trig_s |=> fetch_busy)
    else $error("no fetch after trigger");
  fetch_short_a:
    assert property (fetch_busy && !trig |=> !fetch_busy)
    else $error("fetch longer than one cycle");
  fetch_cause_a:
    assert property ($rose(fetch_busy) |-> $past(trig))
    else $error("fetch without trigger");
  no_fetch_a:
    assert property (trig && sel_reg != `SSC_SEL_PORT |=> !fetch_busy)
    else $error("fetch for non counter select");
  valid_set_a:
    assert property (fetch_s |=> reg_rdata[6])
    else $error("valid low after fetch");
  drop_top_a:
    assert property (reg_rd && reg_addr == `SSC_REG_DATA3 && drop_reg
      |=> reg_rdata == 8'h00)
    else $error("drop word top byte not zero");
endmodule

bind ssc_stats ssc_stats_chk i_ssc_stats_chk (.clk(clk), .reset(reset),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fetch_busy(fetch_busy));

`default_nettype wire

// file: ssc_host.sv
/*
 * Host model reaching the indirect counter window.
 * Assumes strobes are sampled on the rising edge of clk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ssc_cfg.svh"

module ssc_host (
  output logic reg_wr, // write strobe
  output logic reg_rd, // read strobe
  output logic [7:0] reg_addr, // register offset
  output logic [7:0] reg_wdata, // write data
  input wire logic clk, // core clock
  input wire logic [7:0] reg_rdata // read data
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // idle lines are inverted so a stale value never passes for data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    d = reg_rdata;
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask

  // per-port top byte retried while valid is low, eight tries at most
  task automatic fetch(input logic [7:0] sel, input logic [7:0] off,
                       output logic [31:0] w, output logic ok);
    wr(`SSC_REG_SELECT, sel);
    wr(`SSC_REG_TRIGGER, off);
    ok = 1'b0;
    for (int i = 0; i < 8 && !ok; i++) begin
      rd(`SSC_REG_DATA3, w[31:24]);
      ok = sel != `SSC_SEL_PORT || w[30];
    end
    rd(`SSC_REG_DATA2, w[23:16]);
    rd(`SSC_REG_DATA1, w[15:8]);
    rd(`SSC_REG_DATA0, w[7:0]);
  endtask
endmodule

`default_nettype wire

// file: tb_top.sv
/*
 * Self-checking bench of ssc_stats; the host model sits on the
 * register port and the bench plays the MAC event sources.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ssc_cfg.svh"

module tb_top
  import ssc_pkg::*;
;
  logic clk, reset, long_mode, reg_wr, reg_rd, fetch_busy, ok;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, b;
  logic [31:0] w;
  logic [2:0] tx_drop, rx_drop;
  ssc_rx_ev_s [2:0] rx_ev;
  ssc_tx_ev_s [2:0] tx_ev;
  int n_errors, comparisons;

  ssc_stats i_ssc_stats (.clk(clk), .reset(reset), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .long_mode(long_mode), .rx_ev(rx_ev),
    .tx_ev(tx_ev), .tx_drop(tx_drop), .rx_drop(rx_drop),
    .fetch_busy(fetch_busy));
  ssc_host i_ssc_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // reads one per-port counter, which clears it
  task automatic cnt(input logic [7:0] off, input logic [29:0] val);
    i_ssc_host.fetch(`SSC_SEL_PORT, off, w, ok);
    if (!ok) begin
      n_errors++;
      $display("unexpected valid at %h: expected 1 seen 0", off);
      give_verdict();
    end else
      check($sformatf("counter %h", off), w, {2'b01, val});
  endtask

  // f: high_prio crc_ok symbol_err partial all group mac_ctrl flow
  task automatic rx(input int p, input logic [10:0] len,
                    input logic [7:0] f);
    @(negedge clk);
    rx_ev[p] = {1'b1, len, f};
    @(negedge clk);
    rx_ev[p] = '0;
  endtask

  // f: high_prio ok all group flow postponed too_many; c: num coll late
  task automatic tx(input int p, input logic [10:0] len,
                    input logic [6:0] f, input logic [6:0] c);
    @(negedge clk);
    tx_ev[p] = {|len, len, f, c};
    @(negedge clk);
    tx_ev[p] = '0;
  endtask

  task automatic t_regs();
    i_ssc_host.rd(8'h10, b);
    check("unmapped", {24'h0, b}, 32'h0);
    i_ssc_host.wr(`SSC_REG_SELECT, `SSC_SEL_PORT);
    i_ssc_host.rd(`SSC_REG_SELECT, b);
    check("select", {24'h0, b}, 32'h1c);
    i_ssc_host.wr(`SSC_REG_DATA0, 8'h5a);
    i_ssc_host.rd(`SSC_REG_DATA0, b);
    check("read-only byte", {24'h0, b}, 32'h0);
    $display("regs test over");
  endtask

  task automatic t_rx();
    logic [10:0] lens [6] = '{64, 127, 255, 511, 1023, 1522};
    rx(0, 11'd64, 8'h48);
    cnt(8'h00, 30'd64);
    cnt(8'h00, 30'd0);
    cnt(8'h0b, 30'd1);
    cnt(8'h0e, 30'd1);
    rx(1, 11'd1522, 8'hc4);
    cnt(8'h21, 30'd1522);
    cnt(8'h2c, 30'd1);
    rx(0, 11'd64, 8'h47);
    cnt(8'h09, 30'd1);
    cnt(8'h0a, 30'd1);
    cnt(8'h0c, 30'd0);
    cnt(8'h0e, 30'd1);
    rx(2, 11'd100, 8'h40);
    cnt(8'h4d, 30'd1);
    for (int i = 0; i < 6; i++)
      rx(0, lens[i], 8'h40);
    for (int i = 0; i < 6; i++)
      cnt(8'h0e + 8'(i), 30'd1);
    $display("receive class test over");
  endtask

  task automatic t_err();
    rx(2, 11'd30, 8'h40);
    cnt(8'h42, 30'd1);
    rx(2, 11'd30, 8'h00);
    cnt(8'h43, 30'd1);
    rx(2, 11'd1523, 8'h40);
    cnt(8'h44, 30'd1);
    long_mode = 1'b1;
    rx(2, 11'd1523, 8'h40);
    cnt(8'h44, 30'd0);
    rx(2, 11'd1537, 8'h00);
    cnt(8'h45, 30'd1);
    long_mode = 1'b0;
    rx(2, 11'd100, 8'h60);
    cnt(8'h46, 30'd1);
    rx(2, 11'd100, 8'h00);
    cnt(8'h47, 30'd1);
    cnt(8'h48, 30'd0);
    rx(2, 11'd100, 8'h10);
    cnt(8'h48, 30'd1);
    $display("receive error test over");
  endtask

  task automatic t_tx();
    tx(1, 11'd100, 7'h62, 7'h04);
    cnt(8'h35, 30'd100);
    cnt(8'h3a, 30'd1);
    cnt(8'h3b, 30'd1);
    cnt(8'h3e, 30'd1);
    tx(1, 11'd64, 7'h24, 7'h0c);
    cnt(8'h34, 30'd64);
    cnt(8'h37, 30'd1);
    cnt(8'h3f, 30'd1);
    tx(1, 11'd64, 7'h01, 7'h00);
    cnt(8'h3d, 30'd1);
    cnt(8'h34, 30'd0);
    tx(1, 11'd64, 7'h30, 7'h00);
    tx(1, 11'd64, 7'h28, 7'h00);
    cnt(8'h38, 30'd1);
    cnt(8'h39, 30'd1);
    tx(1, 11'd0, 7'h00, 7'h02);
    tx(1, 11'd0, 7'h00, 7'h03);
    cnt(8'h3c, 30'd2);
    cnt(8'h36, 30'd1);
    $display("transmit test over");
  endtask

  task automatic t_refused();
    i_ssc_host.wr(`SSC_REG_TRIGGER, 8'h60);
    i_ssc_host.rd(`SSC_REG_DATA3, b);
    check("valid", {31'h0, b[6]}, 32'h0);
    cnt(8'h36, 30'd0);
    i_ssc_host.wr(`SSC_REG_SELECT, 8'h14);
    i_ssc_host.wr(`SSC_REG_TRIGGER, 8'h02);
    i_ssc_host.rd(`SSC_REG_DATA3, b);
    check("valid", {31'h0, b[6]}, 32'h0);
    $display("refusal test over");
  endtask

  task automatic t_drop();
    for (int i = 0; i < 3; i++) begin
      @(negedge clk);
      tx_drop = 3'b010;
      rx_drop = {i == 0, 2'b00};
      @(negedge clk);
      tx_drop = 3'b000;
      rx_drop = 3'b000;
    end
    for (int i = 0; i < 2; i++) begin
      i_ssc_host.fetch(`SSC_SEL_DROP, 8'h01, w, ok);
      check("drop count", w, 32'h3);
    end
    i_ssc_host.fetch(`SSC_SEL_DROP, 8'h05, w, ok);
    check("drop count", w, 32'h1);
    i_ssc_host.fetch(`SSC_SEL_DROP, 8'h00, w, ok);
    check("drop count", w, 32'h0);
    $display("drop test over");
  endtask

  initial begin
    reset = 1'b1;
    long_mode = 1'b0;
    rx_ev = '0;
    tx_ev = '0;
    tx_drop = 3'b000;
    rx_drop = 3'b000;
    n_errors = 0;
    comparisons = 0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    t_regs();
    t_rx();
    t_err();
    t_tx();
    t_refused();
    t_drop();
    give_verdict();
  end
endmodule

`default_nettype wire
